// ===== rtl/cal_device.sv
// Purpose: Two-channel offset / maximum count calibration with parameter access
// Assumes: Raw samples arrive from same-clock logic, one per cycle at most
// Notes:   Result is one cycle behind the sample; divider is combinational
module cal_device (
    // Clock and reset
    input  wire logic                                sys_clk,
    input  wire logic                                sys_rst,
    // Parameter link
    param_link_if.dev                                link,
    // Raw samples
    input  wire logic                                sample_valid,
    input  wire logic                                sample_ch,
    input  wire logic signed [cal_pkg::VALUE_W-1:0]  sample_raw,
    // Calibrated samples
    output logic                                     cal_valid,
    output logic                                     cal_ch,
    output logic signed [cal_pkg::VALUE_W-1:0]       cal_data
);
    import cal_pkg::*;

    // ----------------------------------------------------------------
    // Per-channel settings
    // ----------------------------------------------------------------
    logic signed [VALUE_W-1:0] offset_q [CHAN_N];
    logic signed [VALUE_W-1:0] offset_d [CHAN_N];
    logic signed [VALUE_W-1:0] maxcnt_q [CHAN_N];
    logic signed [VALUE_W-1:0] maxcnt_d [CHAN_N];

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    logic                      hdr_ok;
    logic                      is_offset;
    logic                      is_maxcnt;
    logic                      req_ch;
    logic signed [VALUE_W-1:0] req_value;
    logic                      range_ok;
    logic                      wr_offset;
    logic                      wr_maxcnt;

    always_comb begin
        // Only the exact header is honoured; anything else is refused
        hdr_ok    = (link.req_len == REQ_LEN) && (link.req_idx_hi == IDX_HI_CAL)
                    && (link.req_sub_idx >= SUB_IDX_FIRST)
                    && (link.req_sub_idx <= SUB_IDX_LAST);
        is_offset = hdr_ok && (link.req_idx_lo == IDX_LO_OFFSET);
        is_maxcnt = hdr_ok && (link.req_idx_lo == IDX_LO_MAXCNT);
        req_ch    = (link.req_sub_idx == SUB_IDX_LAST);
        req_value = {link.req_data2, link.req_data1};
        range_ok  = 1'b0;
        if (is_offset) begin
            range_ok = (req_value >= OFFSET_MIN) && (req_value <= OFFSET_MAX);
        end else if (is_maxcnt) begin
            range_ok = (req_value >= MAXCNT_MIN) && (req_value <= MAXCNT_MAX);
        end
        wr_offset = link.req_valid && link.req_write && is_offset && range_ok;
        wr_maxcnt = link.req_valid && link.req_write && is_maxcnt && range_ok;
    end

    // ----------------------------------------------------------------
    // Setting storage, one copy per channel
    // ----------------------------------------------------------------
    for (genvar ch = 0; ch < CHAN_N; ch++) begin : g_chan
        always_comb begin
            offset_d[ch] = offset_q[ch];
            maxcnt_d[ch] = maxcnt_q[ch];
            // A write touches only the addressed channel
            if (wr_offset && (int'(req_ch) == ch)) begin
                offset_d[ch] = req_value;
            end
            if (wr_maxcnt && (int'(req_ch) == ch)) begin
                maxcnt_d[ch] = req_value;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                offset_q[ch] <= OFFSET_RESET;
                maxcnt_q[ch] <= MAXCNT_RESET;
            end else begin
                offset_q[ch] <= offset_d[ch];
                maxcnt_q[ch] <= maxcnt_d[ch];
            end
        end
    end

    // ----------------------------------------------------------------
    // Answer
    // ----------------------------------------------------------------
    logic                      rsp_valid_q;
    logic                      rsp_valid_d;
    logic                      rsp_ok_q;
    logic                      rsp_ok_d;
    logic [BYTE_W-1:0]         rsp_data1_q;
    logic [BYTE_W-1:0]         rsp_data1_d;
    logic [BYTE_W-1:0]         rsp_data2_q;
    logic [BYTE_W-1:0]         rsp_data2_d;
    logic signed [VALUE_W-1:0] rd_value;

    always_comb begin
        rd_value    = is_maxcnt ? maxcnt_q[req_ch] : offset_q[req_ch];
        rsp_valid_d = link.req_valid;
        rsp_ok_d    = 1'b0;
        rsp_data1_d = rsp_data1_q;
        rsp_data2_d = rsp_data2_q;
        if (link.req_valid) begin
            if (link.req_write) begin
                // Write echoes the setting now in force, old one if refused
                rsp_ok_d = wr_offset || wr_maxcnt;
                if (rsp_ok_d) begin
                    rd_value = req_value;
                end
            end else begin
                rsp_ok_d = is_offset || is_maxcnt;
            end
            rsp_data1_d = rd_value[BYTE_W-1:0];
            rsp_data2_d = rd_value[VALUE_W-1:BYTE_W];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rsp_valid_q <= 1'b0;
            rsp_ok_q    <= 1'b0;
            rsp_data1_q <= 8'h00;
            rsp_data2_q <= 8'h00;
        end else begin
            rsp_valid_q <= rsp_valid_d;
            rsp_ok_q    <= rsp_ok_d;
            rsp_data1_q <= rsp_data1_d;
            rsp_data2_q <= rsp_data2_d;
        end
    end

    assign link.rsp_valid = rsp_valid_q;
    assign link.rsp_ok    = rsp_ok_q;
    assign link.rsp_data1 = rsp_data1_q;
    assign link.rsp_data2 = rsp_data2_q;

    // ----------------------------------------------------------------
    // Calibration datapath
    // ----------------------------------------------------------------
    // Span never drops below 23800 - 8191, so the divisor is never zero.
    // The raw span is not clipped to the settings, so inputs outside the
    // calibration points still extrapolate over the whole bipolar range.
    logic signed [VALUE_W:0]     diff;
    logic signed [VALUE_W:0]     span;
    logic signed [2*VALUE_W+1:0] prod;
    logic signed [2*VALUE_W+1:0] quot;
    logic signed [VALUE_W-1:0]   sat;
    logic                        cal_valid_q;
    logic                        cal_valid_d;
    logic                        cal_ch_q;
    logic                        cal_ch_d;
    logic signed [VALUE_W-1:0]   cal_data_q;
    logic signed [VALUE_W-1:0]   cal_data_d;

    always_comb begin
        // Channel selects its own pair of settings
        diff = 17'(sample_raw) - 17'(offset_q[sample_ch]);
        span = 17'(maxcnt_q[sample_ch]) - 17'(offset_q[sample_ch]);
        // Defaults give span 32000, so the raw count passes unchanged
        prod = 34'(diff) * 34'(FULL_SCALE);
        quot = prod / 34'(span);
        if (quot > 34'(SAT_HI)) begin
            sat = SAT_HI;
        end else if (quot < 34'(SAT_LO)) begin
            sat = SAT_LO;
        end else begin
            sat = quot[VALUE_W-1:0];
        end
        cal_valid_d = sample_valid;
        cal_ch_d    = sample_valid ? sample_ch : cal_ch_q;
        cal_data_d  = sample_valid ? sat : cal_data_q;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cal_valid_q <= 1'b0;
            cal_ch_q    <= 1'b0;
            cal_data_q  <= 16'sh0000;
        end else begin
            cal_valid_q <= cal_valid_d;
            cal_ch_q    <= cal_ch_d;
            cal_data_q  <= cal_data_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign cal_valid = cal_valid_q;
    assign cal_ch    = cal_ch_q;
    assign cal_data  = cal_data_q;

endmodule // cal_device

// ===== rtl/cal_pkg.sv
// Purpose: Shared constants and types for the two-channel calibration stage
// Assumes: One clock, synchronous active-high reset
// Notes:   Parameter requests use an index / sub-index byte layout
package cal_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int BYTE_W  = 8;
    localparam int VALUE_W = 16;
    localparam int CHAN_N  = 2;

    // ----------------------------------------------------------------
    // Request layout
    // ----------------------------------------------------------------
    localparam logic [7:0] REQ_LEN        = 8'h02;
    localparam logic [7:0] IDX_HI_CAL     = 8'h24;
    localparam logic [7:0] IDX_LO_OFFSET  = 8'h00;
    localparam logic [7:0] IDX_LO_MAXCNT  = 8'h01;
    localparam logic [7:0] SUB_IDX_FIRST  = 8'h01;
    localparam logic [7:0] SUB_IDX_LAST   = 8'h02;

    // ----------------------------------------------------------------
    // Ranges and defaults
    // ----------------------------------------------------------------
    localparam logic signed [15:0] OFFSET_MIN    = -16'sd8191;
    localparam logic signed [15:0] OFFSET_MAX    = 16'sd8191;
    localparam logic signed [15:0] OFFSET_RESET  = 16'sd0;
    localparam logic signed [15:0] MAXCNT_MIN    = 16'sd23800;
    localparam logic signed [15:0] MAXCNT_MAX    = 16'sd32760;
    localparam logic signed [15:0] MAXCNT_RESET  = 16'sd32000;
    localparam int                 FULL_SCALE    = 32000;
    localparam logic signed [15:0] SAT_HI        = 16'sh7fff;
    localparam logic signed [15:0] SAT_LO        = -16'sh8000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic {
        PARAM_OFFSET,
        PARAM_MAXCNT
    } param_sel_type;

endpackage : cal_pkg

// ===== rtl/param_link_if.sv
// Purpose: Parameter request link between the upstream requester and the device
// Assumes: Both ends on sys_clk
// Notes:   A request is a one-cycle pulse; the answer is a one-cycle pulse
interface param_link_if;

    // Request, driven by the requester
    logic        req_valid;
    logic        req_write;
    logic [7:0]  req_len;
    logic [7:0]  req_idx_lo;
    logic [7:0]  req_idx_hi;
    logic [7:0]  req_sub_idx;
    logic [7:0]  req_data1;
    logic [7:0]  req_data2;
    // Answer, driven by the device
    logic        rsp_valid;
    logic        rsp_ok;
    logic [7:0]  rsp_data1;
    logic [7:0]  rsp_data2;

    modport dev (
        input  req_valid, req_write, req_len, req_idx_lo, req_idx_hi,
        input  req_sub_idx, req_data1, req_data2,
        output rsp_valid, rsp_ok, rsp_data1, rsp_data2
    );

    modport host (
        output req_valid, req_write, req_len, req_idx_lo, req_idx_hi,
        output req_sub_idx, req_data1, req_data2,
        input  rsp_valid, rsp_ok, rsp_data1, rsp_data2
    );

endinterface : param_link_if

// ===== rtl/param_requester.sv
// Purpose: Upstream end that builds parameter requests from a simple command
// Assumes: Device answers within a bounded time on the same clock
// Notes:   One request outstanding at a time
module param_requester (
    // Clock and reset
    input  wire logic                                sys_clk,
    input  wire logic                                sys_rst,
    // Parameter link
    param_link_if.host                               link,
    // Command side
    input  wire logic                                cmd_valid,
    input  wire logic                                cmd_write,
    input  wire cal_pkg::param_sel_type              cmd_param,
    input  wire logic                                cmd_ch,
    input  wire logic signed [cal_pkg::VALUE_W-1:0]  cmd_value,
    output logic                                     cmd_ready,
    // Result side
    output logic                                     res_valid,
    output logic                                     res_ok,
    output logic signed [cal_pkg::VALUE_W-1:0]       res_value
);
    import cal_pkg::*;

    // ----------------------------------------------------------------
    // Control
    // ----------------------------------------------------------------
    typedef enum logic { ST_IDLE, ST_WAIT } state_type;

    state_type                 state_q, state_d;
    logic                      req_valid_q, req_valid_d;
    logic                      req_write_q, req_write_d;
    logic [BYTE_W-1:0]         idx_lo_q, idx_lo_d;
    logic [BYTE_W-1:0]         sub_q, sub_d;
    logic [BYTE_W-1:0]         data1_q, data1_d;
    logic [BYTE_W-1:0]         data2_q, data2_d;
    logic                      res_valid_q, res_valid_d;
    logic                      res_ok_q, res_ok_d;
    logic signed [VALUE_W-1:0] res_value_q, res_value_d;
    logic                      cmd_ready_q, cmd_ready_d;

    always_comb begin
        state_d     = state_q;
        req_valid_d = 1'b0;
        req_write_d = req_write_q;
        idx_lo_d    = idx_lo_q;
        sub_d       = sub_q;
        data1_d     = data1_q;
        data2_d     = data2_q;
        res_valid_d = 1'b0;
        res_ok_d    = res_ok_q;
        res_value_d = res_value_q;
        case (state_q)
            ST_IDLE: begin
                if (cmd_valid) begin
                    req_valid_d = 1'b1;
                    req_write_d = cmd_write;
                    idx_lo_d    = (cmd_param == PARAM_MAXCNT) ? IDX_LO_MAXCNT
                                                              : IDX_LO_OFFSET;
                    sub_d       = cmd_ch ? SUB_IDX_LAST : SUB_IDX_FIRST;
                    data1_d     = cmd_value[BYTE_W-1:0];
                    data2_d     = cmd_value[VALUE_W-1:BYTE_W];
                    state_d     = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (link.rsp_valid) begin
                    res_valid_d = 1'b1;
                    res_ok_d    = link.rsp_ok;
                    res_value_d = {link.rsp_data2, link.rsp_data1};
                    state_d     = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // Registered so the command side sees a clean flop output
        cmd_ready_d = (state_d == ST_IDLE);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q     <= ST_IDLE;
            req_valid_q <= 1'b0;
            req_write_q <= 1'b0;
            idx_lo_q    <= IDX_LO_OFFSET;
            sub_q       <= SUB_IDX_FIRST;
            data1_q     <= 8'h00;
            data2_q     <= 8'h00;
            res_valid_q <= 1'b0;
            res_ok_q    <= 1'b0;
            res_value_q <= 16'sh0000;
            cmd_ready_q <= 1'b1;
        end else begin
            state_q     <= state_d;
            req_valid_q <= req_valid_d;
            req_write_q <= req_write_d;
            idx_lo_q    <= idx_lo_d;
            sub_q       <= sub_d;
            data1_q     <= data1_d;
            data2_q     <= data2_d;
            res_valid_q <= res_valid_d;
            res_ok_q    <= res_ok_d;
            res_value_q <= res_value_d;
            cmd_ready_q <= cmd_ready_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign link.req_valid   = req_valid_q;
    assign link.req_write   = req_write_q;
    assign link.req_len     = REQ_LEN;
    assign link.req_idx_lo  = idx_lo_q;
    assign link.req_idx_hi  = IDX_HI_CAL;
    assign link.req_sub_idx = sub_q;
    assign link.req_data1   = data1_q;
    assign link.req_data2   = data2_q;
    assign cmd_ready        = cmd_ready_q;
    assign res_valid        = res_valid_q;
    assign res_ok           = res_ok_q;
    assign res_value        = res_value_q;

endmodule // param_requester

// ===== tb/cal_chk.sv
// Purpose: Link assertions between the parameter requester and the calibration device
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only link signals; sample results are judged by the bench
module cal_chk (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    // Request
    input wire logic       req_valid,
    input wire logic       req_write,
    input wire logic [7:0] req_len,
    input wire logic [7:0] req_idx_lo,
    input wire logic [7:0] req_idx_hi,
    input wire logic [7:0] req_sub_idx,
    input wire logic [7:0] req_data1,
    input wire logic [7:0] req_data2,
    // Answer
    input wire logic       rsp_valid,
    input wire logic       rsp_ok,
    input wire logic [7:0] rsp_data1,
    input wire logic [7:0] rsp_data2
);
    timeunit 1ns;
    timeprecision 1ps;
    import cal_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    logic signed [15:0] val;
    logic               hdr_ok;
    logic               bad;
    assign val    = {req_data2, req_data1};
    assign hdr_ok = req_len == REQ_LEN && req_idx_hi == IDX_HI_CAL && req_idx_lo <= IDX_LO_MAXCNT
                    && req_sub_idx >= SUB_IDX_FIRST && req_sub_idx <= SUB_IDX_LAST;
    assign bad    = (req_idx_lo == IDX_LO_OFFSET) ? (val < OFFSET_MIN || val > OFFSET_MAX)
                                                  : (val < MAXCNT_MIN || val > MAXCNT_MAX);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    rsp_timing_a: assert property (req_valid |=> rsp_valid)
        else $error("answer missing one cycle after request");
    rsp_cause_a: assert property (rsp_valid |-> $past(req_valid))
        else $error("answer without request");
    req_header_a: assert property (req_valid |-> hdr_ok)
        else $error("request header malformed");
    req_pulse_a: assert property (req_valid |=> !req_valid [*2])
        else $error("request not a lone pulse");
    read_ok_a: assert property (req_valid && !req_write |=> rsp_ok)
        else $error("read refused");
    off_range_a: assert property (req_valid && req_write
        && req_idx_lo == IDX_LO_OFFSET && bad |=> rsp_valid && !rsp_ok)
        else $error("offset out of range accepted");
    max_range_a: assert property (req_valid && req_write
        && req_idx_lo == IDX_LO_MAXCNT && bad |=> rsp_valid && !rsp_ok)
        else $error("max count out of range accepted");
    write_echo_a: assert property (req_valid && req_write && !bad
        |=> rsp_ok && {rsp_data2, rsp_data1} == $past(val))
        else $error("write echo wrong");
endmodule // cal_chk

// ===== tb/test_analog_input_calibration.sv
// Purpose: Self-checking bench for requester and calibration device back to back
// Assumes: Inputs driven on the falling edge, results sampled there too
// Notes:   A second device faces the bench directly to send malformed requests
module test_analog_input_calibration;
    timeunit 1ns;
    timeprecision 1ps;
    import cal_pkg::*;
    logic               sys_clk, sys_rst, cmd_valid, cmd_write, cmd_ch, cmd_ready;
    logic               res_valid, res_ok, sample_valid, sample_ch, cal_valid, cal_ch;
    param_sel_type      cmd_param;
    logic signed [15:0] cmd_value, res_value, sample_raw, cal_data;
    int                 miscompares, compares;
    int                 off [2];
    int                 mx [2];
    int                 bv [8] = '{8191, 8192, -8191, -8192, 23800, 23799, 32760, 32761};
    bit [31:0]          seed = 32'h00015847;
    bit [31:0]          t;
    int                 rv;
    param_link_if l1 ();
    param_link_if l2 ();
    param_requester param_requester_i (.sys_clk, .sys_rst, .link(l1), .cmd_valid, .cmd_write,
        .cmd_param, .cmd_ch, .cmd_value, .cmd_ready, .res_valid, .res_ok, .res_value);
    cal_device cal_device_i (.sys_clk, .sys_rst, .link(l1), .sample_valid, .sample_ch,
        .sample_raw, .cal_valid, .cal_ch, .cal_data);
    // Fault end: its sample side is idle, only the link is under test
    cal_device cal_device_fault_i (.sys_clk, .sys_rst, .link(l2), .sample_valid(1'b0),
        .sample_ch(1'b0), .sample_raw(16'sh0000), .cal_valid(), .cal_ch(), .cal_data());
    cal_chk cal_chk_i (.sys_clk, .sys_rst, .req_valid(l1.req_valid), .req_write(l1.req_write),
        .req_len(l1.req_len), .req_idx_lo(l1.req_idx_lo), .req_idx_hi(l1.req_idx_hi),
        .req_sub_idx(l1.req_sub_idx), .req_data1(l1.req_data1), .req_data2(l1.req_data2),
        .rsp_valid(l1.rsp_valid), .rsp_ok(l1.rsp_ok), .rsp_data1(l1.rsp_data1),
        .rsp_data2(l1.rsp_data2));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic bit [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int r16();
        logic signed [15:0] v;
        v = 16'(rnd());
        return int'(v);
    endfunction
    function automatic bit inr(bit p, int v);
        return p ? (v >= MAXCNT_MIN && v <= MAXCNT_MAX) : (v >= OFFSET_MIN && v <= OFFSET_MAX);
    endfunction
    // Wide product so a large difference cannot wrap before the clamp
    function automatic logic [15:0] calc(int raw, int o, int m);
        longint q;
        q = longint'(raw - o) * FULL_SCALE / (m - o);
        if (q > 32767) q = 32767;
        if (q < -32768) q = -32768;
        return 16'(q);
    endfunction
    task automatic check(logic [15:0] got, logic [15:0] exp, string m);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic op(bit w, bit p, bit ch, int v);
        bit ok;
        int e;
        int n;
        ok = !w || inr(p, v);
        e = p ? mx[ch] : off[ch];
        if (w && ok) e = v;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        cmd_valid = 1;
        cmd_write = w;
        cmd_param = param_sel_type'(p);
        cmd_ch = ch;
        cmd_value = 16'(v);
        @(negedge sys_clk);
        cmd_valid = 0;
        check({15'h0, cmd_ready}, 16'h0000, "ready while busy");
        n = 0;
        while (res_valid !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        check({15'h0, res_valid}, 16'h0001, "result strobe");
        check({15'h0, res_ok}, {15'h0, ok}, "result status");
        check(res_value, 16'(e), "result value");
        if (p) mx[ch] = e;
        else off[ch] = e;
    endtask
    // Leaves the strobe high so consecutive calls give back-to-back samples
    task automatic smp(bit ch, int raw);
        sample_valid = 1;
        sample_ch = ch;
        sample_raw = 16'(raw);
        @(negedge sys_clk);
        check({15'h0, cal_valid}, 16'h0001, "sample strobe");
        check({15'h0, cal_ch}, {15'h0, ch}, "sample channel");
        check(cal_data, calc(raw, off[ch], mx[ch]), "sample value");
    endtask
    task automatic hdr(logic [7:0] len, lo, hi, sub, d1, d2, bit ok);
        l2.req_valid = 1;
        l2.req_write = 1;
        l2.req_len = len;
        l2.req_idx_lo = lo;
        l2.req_idx_hi = hi;
        l2.req_sub_idx = sub;
        l2.req_data1 = d1;
        l2.req_data2 = d2;
        @(negedge sys_clk);
        check({15'h0, l2.rsp_valid}, 16'h0001, "fault answer strobe");
        check({15'h0, l2.rsp_ok}, {15'h0, ok}, "fault answer status");
    endtask
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    initial begin
        {sys_rst, cmd_valid, cmd_write, cmd_ch, cmd_value} = {4'h8, 16'h0000};
        cmd_param = PARAM_OFFSET;
        {sample_valid, sample_ch, sample_raw} = 18'h00000;
        {l2.req_valid, l2.req_write, l2.req_len, l2.req_idx_lo} = 18'h00000;
        {l2.req_idx_hi, l2.req_sub_idx, l2.req_data1, l2.req_data2} = 32'h00000000;
        off = '{0, 0};
        mx = '{32000, 32000};
        repeat (2) @(negedge sys_clk);
        sys_rst = 0;
        for (int i = 0; i < 4; i++) op(0, i[1], i[0], 0);
        for (int i = 0; i < 8; i++) smp(i[0], r16());
        op(1, 0, 0, 64);
        op(1, 1, 0, 31872);
        smp(0, 8016);
        smp(1, 8016);
        smp(0, 31872);
        smp(0, 64);
        sample_valid = 0;
        for (int i = 0; i < 8; i++) op(1, i >= 4, 1, bv[i]);
        for (int i = 0; i < 4; i++) op(0, i[1], i[0], 0);
        op(1, 0, 1, 8191);
        op(1, 1, 1, 23800);
        smp(1, 32767);
        smp(1, -32768);
        sample_valid = 0;
        for (int i = 0; i < 40; i++) begin
            t = rnd();
            rv = t[1] ? 23700 + int'(t[31:16] % 9200) : int'(t[31:16] % 17000) - 8500;
            op(t[0], t[1], t[2], rv);
            smp(t[3], r16());
            sample_valid = 0;
        end
        // Reset in mid-run must bring back the default settings
        sys_rst = 1;
        repeat (2) @(negedge sys_clk);
        sys_rst = 0;
        off = '{0, 0};
        mx = '{32000, 32000};
        for (int i = 0; i < 4; i++) op(0, i[1], i[0], 0);
        smp(1, 8016);
        sample_valid = 0;
        hdr(8'h03, 8'h00, 8'h24, 8'h01, 8'h40, 8'h00, 0);
        hdr(8'h02, 8'h00, 8'h25, 8'h01, 8'h40, 8'h00, 0);
        hdr(8'h02, 8'h02, 8'h24, 8'h01, 8'h40, 8'h00, 0);
        hdr(8'h02, 8'h01, 8'h24, 8'h00, 8'h00, 8'h7d, 0);
        hdr(8'h02, 8'h01, 8'h24, 8'h03, 8'h00, 8'h7d, 0);
        hdr(8'h02, 8'h00, 8'h24, 8'h02, 8'h01, 8'he0, 1);
        l2.req_valid = 0;
        check({l2.rsp_data2, l2.rsp_data1}, 16'he001, "fault echo");
        print_verdict();
    end
endmodule // test_analog_input_calibration
